//--- loop_filter_coefficient_bank.sv
// Coefficient bank and adaptive dead-time gate for the digital compensation filter
//
// Implementation choice: the address-and-strobe port.

// Contract
// [R1] Soft-start gain code selects 1, 2, 4, 8
// [R2] Per-mode 8-bit low-frequency gain, monotonic
// [R3] Per-mode 8-bit high-frequency gain, monotonic
// [R4] Gain step 0.3 dB, span 20 dB
// [R5] Per-mode 8-bit final zero setting
// [R6] Per-mode 8-bit final pole setting
// [R7] Separate independent light-load coefficient set
// [R8] Offsets applied while current below threshold
// [R9] Threshold code scales with sense range
// [R10] Offset 5 ns steps, polarity selects direction
// [R11] Soft start, then light load, else normal
// [R12] Reserved bits read back, no effect
module loop_filter_coefficient_bank (
    input  wire logic                                   core_clk,
    input  wire logic                                   reset_n,
    input  wire logic [7:0]                             addr,
    input  wire logic [7:0]                             wr_data,
    input  wire logic                                   wr_en,
    input  wire logic                                   rd_en,
    output logic      [7:0]                             rd_data,
    input  wire logic                                   soft_start_active,
    input  wire logic                                   light_load_active,
    input  wire logic [1:0]                             sense_range,
    input  wire logic [15:0]                            load_current_sense_input,
    input  wire loop_filter_pkg::dead_code_type [7:0]   dead_time_codes,
    output loop_filter_pkg::mode_type                   active_mode,
    output loop_filter_pkg::coeff_set_type              active_coeffs,
    output logic      [3:0]                             soft_start_gain,
    output logic      [9:0]                             low_freq_gain_db10,
    output logic      [9:0]                             high_freq_gain_db10,
    output logic                                        dead_time_active,
    output logic signed [7:0]                           dead_time_shift_ns [8]
);

    // Whole state of the block in one record
    typedef struct packed {
        logic [9:0][7:0]             regs;        // Software-visible storage
        logic [7:0]                  rd_data;     // Read answer, one cycle late
        loop_filter_pkg::mode_type   mode;        // Mode in use by the filter
        loop_filter_pkg::coeff_set_type coeffs;   // Coefficients in use
        logic [3:0]                  soft_gain;   // Soft-start multiplier
        logic [9:0]                  lf_db10;     // Low-frequency gain, 0.1 dB
        logic [9:0]                  hf_db10;     // High-frequency gain, 0.1 dB
        logic                        dt_active;   // Offsets in force
        logic [7:0][7:0]             shift_ns;    // Signed shift per edge
    } bank_state_type;

    bank_state_type state_reg;   // Registered state
    bank_state_type state_next;  // Next state

    // True when the offset falls inside the bank
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a >= loop_filter_pkg::OFS_SOFT_START_FILTER_GAIN)
                 && (a <= loop_filter_pkg::OFS_DEAD_TIME_THRESHOLD);
    endfunction

    // Storage index of a mapped offset
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [7:0] diff;
        diff      = a - loop_filter_pkg::OFS_SOFT_START_FILTER_GAIN;
        reg_index = diff[3:0];
    endfunction

    // Gain code to tenths of a dB, clipped at the span so it never falls
    function automatic logic [9:0] gain_db10(input logic [7:0] code);
        logic [9:0] raw;
        raw = 10'(code) * loop_filter_pkg::GAIN_STEP_DB10;
        gain_db10 = (raw > loop_filter_pkg::GAIN_SPAN_DB10)
                  ? loop_filter_pkg::GAIN_SPAN_DB10 : raw;
    endfunction

    // Threshold in units of 10 uV for a code and a nominal sense range
    function automatic logic [15:0] threshold_10uv(input logic [1:0] range,
                                                   input logic [2:0] code);
        logic [15:0] t_low;
        logic [15:0] t_mid;
        logic [15:0] t_high;
        t_low  = 16'h0000;
        t_mid  = 16'h0000;
        t_high = 16'h0000;
        case (code)
            3'h0: begin
                t_low = 16'd0;    t_mid = 16'd0;    t_high = 16'd0;
            end
            3'h1: begin
                t_low = 16'd390;  t_mid = 16'd780;  t_high = 16'd1560;
            end
            3'h2: begin
                t_low = 16'd780;  t_mid = 16'd1560; t_high = 16'd3125;
            end
            3'h3: begin
                t_low = 16'd1170; t_mid = 16'd2350; t_high = 16'd4700;
            end
            3'h4: begin
                t_low = 16'd1550; t_mid = 16'd3100; t_high = 16'd6250;
            end
            3'h5: begin
                t_low = 16'd1950; t_mid = 16'd3900; t_high = 16'd7800;
            end
            3'h6: begin
                t_low = 16'd2350; t_mid = 16'd4700; t_high = 16'd9400;
            end
            default: begin
                t_low = 16'd2700; t_mid = 16'd5400; t_high = 16'd10900;
            end
        endcase
        // The unused range code behaves as the widest range
        if (range == loop_filter_pkg::RANGE_37M5) begin
            threshold_10uv = t_low;
        end else if (range == loop_filter_pkg::RANGE_75M) begin
            threshold_10uv = t_mid;
        end else begin
            threshold_10uv = t_high;
        end
    endfunction

    // Offset code to a signed shift in ns; negative polarity shifts the other way
    function automatic logic [7:0] offset_ns(input loop_filter_pkg::dead_code_type c);
        logic [7:0] mag;
        mag = 8'(c.magnitude) * loop_filter_pkg::DEAD_STEP_NS;
        offset_ns = c.negative ? 8'(-mag) : mag;
    endfunction

    // Next-state logic: register port, mode choice, coefficient steering, dead-time gate
    always_comb begin
        logic [3:0]  idx;
        logic [15:0] thresh;
        logic [2:0]  tcode;
        idx        = reg_index(addr);
        thresh     = 16'h0000;
        tcode      = 3'h0;
        state_next = state_reg;

        // Writes store all eight bits, reserved ones included
        if (wr_en && is_mapped(addr)) begin
            state_next.regs[idx] = wr_data;  // [R12]
        end

        // Reads answer from the stored value in the following cycle only
        if (rd_en) begin
            state_next.rd_data = is_mapped(addr) ? state_reg.regs[idx]
                                                 : loop_filter_pkg::RD_UNMAPPED;
        end else begin
            state_next.rd_data = 8'h00;
        end

        // Soft start outranks light load; normal otherwise
        if (soft_start_active) begin
            state_next.mode = loop_filter_pkg::MODE_SOFT;  // [R11]
        end else if (light_load_active) begin
            state_next.mode = loop_filter_pkg::MODE_LIGHT;  // [R11]
        end else begin
            state_next.mode = loop_filter_pkg::MODE_NORMAL;  // [R11]
        end

        // Only the low two bits of the soft-start register matter
        state_next.soft_gain = 4'h1
            << state_reg.regs[loop_filter_pkg::IDX_SOFT_GAIN][1:0];  // [R1] [R12]

        // Light load draws on its own four registers
        if (light_load_active && !soft_start_active) begin
            state_next.coeffs = {state_reg.regs[loop_filter_pkg::IDX_LIGHT_LF],
                                 state_reg.regs[loop_filter_pkg::IDX_LIGHT_LF + 4'h1],
                                 state_reg.regs[loop_filter_pkg::IDX_LIGHT_LF + 4'h2],
                                 state_reg.regs[loop_filter_pkg::IDX_LIGHT_LF + 4'h3]
                                };  // [R7]
        end else begin
            // Normal set also stays presented in soft start for the datapath handoff
            state_next.coeffs = {state_reg.regs[loop_filter_pkg::IDX_NORMAL_LF],
                                 state_reg.regs[loop_filter_pkg::IDX_NORMAL_LF + 4'h1],
                                 state_reg.regs[loop_filter_pkg::IDX_NORMAL_LF + 4'h2],
                                 state_reg.regs[loop_filter_pkg::IDX_NORMAL_LF + 4'h3]
                                };  // [R2] [R3] [R5] [R6]
        end

        // Gains in dB follow the set now chosen
        state_next.lf_db10 = gain_db10(state_next.coeffs.low_freq_gain);  // [R2] [R4]
        state_next.hf_db10 = gain_db10(state_next.coeffs.high_freq_gain);  // [R3] [R4]

        // Threshold compare; reserved bits never reach it
        tcode  = state_reg.regs[loop_filter_pkg::IDX_THRESHOLD][2:0];  // [R12]
        thresh = threshold_10uv(sense_range, tcode);  // [R9]
        state_next.dt_active = (load_current_sense_input < thresh);  // [R8]

        // Offsets only while under the threshold, otherwise nominal timing
        for (int e = 0; e < loop_filter_pkg::DEAD_EDGES; e++) begin
            state_next.shift_ns[e] = state_next.dt_active
                                   ? offset_ns(dead_time_codes[e]) : 8'h00;  // [R10]
        end
    end

    // State register; asynchronous reset to constants
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg           <= '0;
            state_reg.mode      <= loop_filter_pkg::MODE_NORMAL;
            state_reg.soft_gain <= 4'h1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign rd_data             = state_reg.rd_data;
    assign active_mode         = state_reg.mode;
    assign active_coeffs       = state_reg.coeffs;
    assign soft_start_gain     = state_reg.soft_gain;
    assign low_freq_gain_db10  = state_reg.lf_db10;
    assign high_freq_gain_db10 = state_reg.hf_db10;
    assign dead_time_active    = state_reg.dt_active;

    // Unpack per-edge shifts for the timing block
    always_comb begin
        for (int e = 0; e < loop_filter_pkg::DEAD_EDGES; e++) begin
            dead_time_shift_ns[e] = signed'(state_reg.shift_ns[e]);
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // A write then a read of the same offset returns the written byte
    sequence mapped_write;
        wr_en && !rd_en && is_mapped(addr);
    endsequence
    sequence read_at(logic [7:0] a);
        rd_en && addr == a;
    endsequence

    // Offset and byte are caught at the write so a read elsewhere never matches
    property write_read_back;
        logic [7:0] a;
        logic [7:0] d;
        (mapped_write, a = addr, d = wr_data) ##1 read_at(a) |=> rd_data == d;
    endproperty

    write_readback_a: assert property (write_read_back)  // [R12]
        else $error("written byte not read back");

    unmapped_read_a: assert property (rd_en && !is_mapped(addr) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    read_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data outside its cycle");

    soft_gain_a: assert property ($past(state_reg.regs[0][1:0]) == 2'h3
                                  |-> soft_start_gain == 4'h8)  // [R1]
        else $error("soft start gain decode wrong");

    mode_priority_a: assert property (soft_start_active |=> active_mode == loop_filter_pkg::MODE_SOFT
                                      ##0 active_coeffs.low_freq_gain == $past(state_reg.regs[1]))  // [R11]
        else $error("soft start not taking precedence");

    light_set_a: assert property (light_load_active && !soft_start_active
                                  |=> active_coeffs == $past({state_reg.regs[5], state_reg.regs[6],
                                                              state_reg.regs[7], state_reg.regs[8]}))  // [R7]
        else $error("light load set not applied");

    normal_set_a: assert property (!light_load_active && !soft_start_active
                                   |=> active_coeffs.zero_position == $past(state_reg.regs[2])
                                    && active_coeffs.pole_position == $past(state_reg.regs[3]))  // [R5]
        else $error("normal zero or pole not applied");

    gain_span_a: assert property (low_freq_gain_db10 <= 10'd200 && high_freq_gain_db10 <= 10'd200
                                  && (active_coeffs.high_freq_gain == 8'd10
                                      -> high_freq_gain_db10 == 10'd30))  // [R4]
        else $error("gain dB mapping wrong");

    threshold_gate_a: assert property (dead_time_active == ($past(load_current_sense_input)
                                       < threshold_10uv($past(sense_range),
                                                        $past(state_reg.regs[9][2:0]))))  // [R8]
        else $error("dead time gate disagrees with threshold");

    zero_code_a: assert property ($past(state_reg.regs[9][2:0]) == 3'h0 |-> !dead_time_active)  // [R9]
        else $error("zero threshold enabled offsets");

    shift_gate_a: assert property (!dead_time_active |-> dead_time_shift_ns[0] == 8'sd0
                                   && dead_time_shift_ns[7] == 8'sd0)  // [R10]
        else $error("offset applied above threshold");

    shift_step_a: assert property (dead_time_active && $past(dead_time_codes[0]) == 4'h7
                                   |-> dead_time_shift_ns[0] == 8'sd35)  // [R10]
        else $error("offset step not 5 ns");

endmodule

//--- loop_filter_pkg.sv
// Package with the register map, field layout and types of the loop filter coefficient bank
package loop_filter_pkg;

    // Register offsets as seen on the plain register port
    localparam logic [7:0] OFS_SOFT_START_FILTER_GAIN    = 8'h5F;
    localparam logic [7:0] OFS_NORMAL_LOW_FREQ_GAIN      = 8'h60;
    localparam logic [7:0] OFS_NORMAL_ZERO_POSITION      = 8'h61;
    localparam logic [7:0] OFS_NORMAL_POLE_POSITION      = 8'h62;
    localparam logic [7:0] OFS_NORMAL_HIGH_FREQ_GAIN     = 8'h63;
    localparam logic [7:0] OFS_LIGHT_LOAD_LOW_FREQ_GAIN  = 8'h64;
    localparam logic [7:0] OFS_LIGHT_LOAD_ZERO_POSITION  = 8'h65;
    localparam logic [7:0] OFS_LIGHT_LOAD_POLE_POSITION  = 8'h66;
    localparam logic [7:0] OFS_LIGHT_LOAD_HIGH_FREQ_GAIN = 8'h67;
    localparam logic [7:0] OFS_DEAD_TIME_THRESHOLD       = 8'h68;

    // Register file geometry: ten contiguous byte registers
    localparam int unsigned REG_COUNT = 10;
    localparam logic [7:0]  REG_RESET = 8'h00;

    // Index of each register inside the storage array
    localparam logic [3:0] IDX_SOFT_GAIN  = 4'h0;
    localparam logic [3:0] IDX_NORMAL_LF  = 4'h1;
    localparam logic [3:0] IDX_LIGHT_LF   = 4'h5;
    localparam logic [3:0] IDX_THRESHOLD  = 4'h9;

    // Field positions
    localparam int unsigned SOFT_GAIN_LSB = 0;
    localparam int unsigned THRESH_LSB    = 0;

    // Gain steps in tenths of a dB, and the programmable span
    localparam logic [9:0] GAIN_STEP_DB10 = 10'h003;
    localparam logic [9:0] GAIN_SPAN_DB10 = 10'h0C8;

    // Dead-time offset step and largest magnitude, in ns
    localparam logic [7:0] DEAD_STEP_NS   = 8'h05;
    localparam logic [7:0] DEAD_MAX_NS    = 8'h23;
    localparam int unsigned DEAD_EDGES    = 8;

    // Sense range selector codes
    localparam logic [1:0] RANGE_37M5 = 2'h0;
    localparam logic [1:0] RANGE_75M  = 2'h1;

    // Output read back for an unmapped offset
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Loop filter mode
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_LIGHT,
        MODE_SOFT
    } mode_type;

    // One compensation coefficient set
    typedef struct packed {
        logic [7:0] low_freq_gain;
        logic [7:0] zero_position;
        logic [7:0] pole_position;
        logic [7:0] high_freq_gain;
    } coeff_set_type;

    // One dead-time offset code: polarity plus magnitude
    typedef struct packed {
        logic       negative;
        logic [2:0] magnitude;
    } dead_code_type;

endpackage

//--- test_loop_filter_coefficient_bank.sv
// Self-checking bench for the loop filter coefficient bank
module test_loop_filter_coefficient_bank;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                 core_clk;
    logic                                 reset_n;
    logic [7:0]                           addr;
    logic [7:0]                           wr_data;
    logic                                 wr_en;
    logic                                 rd_en;
    logic [7:0]                           rd_data;
    logic                                 soft_start_active;
    logic                                 light_load_active;
    logic [1:0]                           sense_range;
    logic [15:0]                          load_current_sense_input;
    loop_filter_pkg::dead_code_type [7:0] dead_time_codes;
    loop_filter_pkg::mode_type            active_mode;
    loop_filter_pkg::coeff_set_type       active_coeffs;
    logic [3:0]                           soft_start_gain;
    logic [9:0]                           low_freq_gain_db10;
    logic [9:0]                           high_freq_gain_db10;
    logic                                 dead_time_active;
    logic signed [7:0]                    dead_time_shift_ns [8];
    int                                   err_count;
    int                                   n_compared;
    // Values written at 0x5F..0x68; reserved bits set so their read back is seen
    logic [7:0] vals [10] = '{8'hfd, 8'h42, 8'h5a, 8'h6b, 8'h43, 8'h05, 8'h33, 8'h44, 8'h00, 8'hf9};
    // Thresholds in 10 uV per code, for the 37.5, 75 and 150 mV ranges
    int thr [3][8] = '{'{0, 390, 780, 1170, 1550, 1950, 2350, 2700},
                       '{0, 780, 1560, 2350, 3100, 3900, 4700, 5400},
                       '{0, 1560, 3125, 4700, 6250, 7800, 9400, 10900}};

    loop_filter_coefficient_bank u_dut (.core_clk(core_clk), .reset_n(reset_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .soft_start_active(soft_start_active), .light_load_active(light_load_active),
        .sense_range(sense_range), .load_current_sense_input(load_current_sense_input),
        .dead_time_codes(dead_time_codes), .active_mode(active_mode),
        .active_coeffs(active_coeffs), .soft_start_gain(soft_start_gain),
        .low_freq_gain_db10(low_freq_gain_db10), .high_freq_gain_db10(high_freq_gain_db10),
        .dead_time_active(dead_time_active), .dead_time_shift_ns(dead_time_shift_ns));

    // Free running 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Count and report one comparison; case inequality so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so the strobe is never driven twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // One-cycle read strobe; data is only valid in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("rd_data at %h", a), {24'h00_0000, exp}, {24'h00_0000, rd_data});
    endtask

    // Outputs are registered: two edges cover a register write or an input change
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Reset of 4 cycles, then mode, coefficients, soft gain, dead-time flag and every register must show its reset value
    task automatic test_reset_values;
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        chk("mode", {30'h0000_0000, loop_filter_pkg::MODE_NORMAL}, {30'h0000_0000, active_mode});
        chk("coeffs", 32'h0000_0000, active_coeffs);
        chk("soft gain", 32'h0000_0001, {28'h000_0000, soft_start_gain});
        chk("dead active", 32'h0000_0000, {31'h0000_0000, dead_time_active});
        for (int i = 0; i < 10; i++) rd_chk(8'h5f + 8'(i), 8'h00);
        $display("test_reset_values finished");
    endtask

    // Every byte stored whole, reserved bits too; unmapped offsets ignore writes, read 0
    task automatic test_reg_rw;
        wr(8'h5e, 8'hff);
        wr(8'h69, 8'hff);
        for (int i = 0; i < 10; i++) wr(8'h5f + 8'(i), vals[i]);
        for (int i = 0; i < 10; i++) rd_chk(8'h5f + 8'(i), vals[i]);
        rd_chk(8'h5e, 8'h00);
        rd_chk(8'h69, 8'h00);
        $display("test_reg_rw finished");
    endtask

    // Write then read with no gap; the read must see the byte just written
    task automatic test_back_to_back;
        @(posedge core_clk);
        addr <= 8'h61;
        wr_data <= 8'ha5;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_data after write", 32'h0000_00a5, {24'h00_0000, rd_data});
        wr(8'h61, vals[2]);
        $display("test_back_to_back finished");
    endtask

    // All four soft start codes, with the reserved bits high to prove they are ignored
    task automatic test_soft_gain;
        @(posedge core_clk);
        soft_start_active <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h5f, 8'hfc | 8'(c));
            settle();
            chk("soft gain", 32'(1 << c), {28'h000_0000, soft_start_gain});
            chk("mode", {30'h0000_0000, loop_filter_pkg::MODE_SOFT}, {30'h0000_0000, active_mode});
        end
        $display("test_soft_gain finished");
    endtask

    // Normal, light, then soft over light; gains 3 tenths of dB per code, clipped at 200
    task automatic test_mode_select;
        logic [1:0]  sl [3] = '{2'h0, 2'h1, 2'h3};
        logic [31:0] exp_c;
        int          base;
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            soft_start_active <= sl[k][1];
            light_load_active <= sl[k][0];
            settle();
            base = (k == 1) ? 5 : 1;
            exp_c = {vals[base], vals[base + 1], vals[base + 2], vals[base + 3]};
            chk("mode", (k == 0) ? 32'h0000_0000 : (k == 1) ? {30'h0, loop_filter_pkg::MODE_LIGHT}
                : {30'h0, loop_filter_pkg::MODE_SOFT}, {30'h0000_0000, active_mode});
            chk("coeffs", exp_c, active_coeffs);
            if (k < 2) begin
                chk("lf db", 32'((vals[base] * 3 > 200) ? 200 : vals[base] * 3),
                    {22'h00_0000, low_freq_gain_db10});
                chk("hf db", 32'((vals[base + 3] * 3 > 200) ? 200 : vals[base + 3] * 3),
                    {22'h00_0000, high_freq_gain_db10});
            end
        end
        @(posedge core_clk);
        soft_start_active <= 1'b0;
        light_load_active <= 1'b0;
        $display("test_mode_select finished");
    endtask

    // Strict less-than against the thresholds of codes 1 to 7, one below and exactly at it, every range
    task automatic test_dead_time;
        int mag;
        for (int r = 0; r < 4; r++) begin
            for (int c = 1; c < 8; c++) begin
                wr(8'h68, 8'hf8 | 8'(c));
                for (int k = 0; k < 2; k++) begin
                    @(posedge core_clk);
                    sense_range <= 2'(r);
                    load_current_sense_input <= 16'(thr[(r > 2) ? 2 : r][c] - 1 + k);
                    settle();
                    chk($sformatf("dead active r%0d c%0d", r, c), 32'(k == 0),
                        {31'h0000_0000, dead_time_active});
                end
            end
        end
        // Below threshold the shifts follow the codes; above it they return to zero
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            load_current_sense_input <= (k == 0) ? 16'h0000 : 16'hffff;
            settle();
            for (int e = 0; e < 8; e++) begin
                mag = (k == 0) ? 5 * (7 - e) : 0;
                chk($sformatf("shift %0d", e), {24'h00_0000, 8'((e % 2) ? -mag : mag)},
                    {24'h00_0000, dead_time_shift_ns[e]});
            end
        end
        $display("test_dead_time finished");
    endtask

    // Single place where the run ends
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; far above the length of the full sequence
    initial begin
        repeat (20000) @(posedge core_clk);
        $display("MISMATCH watchdog expected finish seen timeout");
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        reset_n = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        soft_start_active = 1'b0;
        light_load_active = 1'b0;
        sense_range = 2'h0;
        load_current_sense_input = 16'h0000;
        for (int e = 0; e < 8; e++) dead_time_codes[e] = {1'(e % 2), 3'(7 - e)};
        test_reset_values();
        test_reg_rw();
        test_back_to_back();
        test_soft_gain();
        test_mode_select();
        test_dead_time();
        // A second reset in mid-run must clear all that was written
        test_reset_values();
        tally_and_finish();
    end
endmodule
